// ---- sppm_cfg.svh ----
// Timing and layout constants for the single-wire push-pull master.
// Assumes inclusion by the main module only.
`ifndef SPPM_CFG_SVH
`define SPPM_CFG_SVH
`define SPPM_START_SLOTS 3
`define SPPM_DATA_BITS 5
`define SPPM_ADDR_BITS 3
`define SPPM_PULL_BITS 3
`define SPPM_SUB_PER_SLOT 16
`define SPPM_DIV_DEFAULT 13'h0001
`define SPPM_RX_FIXED_HI 4'h5
`define SPPM_RX_FIXED_LO 1'b1
`define SPPM_EOF_SLOTS 4
`endif

// ---- sppm_pkg.sv ----
// Types for the single-wire push-pull master.
// Assumes the timing header is available to the compile.
package sppm_pkg;
    typedef enum logic [6:0] {
        SPPM_IDLE  = 7'b0000001,
        SPPM_START = 7'b0000010,
        SPPM_PUSH  = 7'b0000100,
        SPPM_PSYNC = 7'b0001000,
        SPPM_PULL  = 7'b0010000,
        SPPM_EOF   = 7'b0100000,
        SPPM_DONE  = 7'b1000000
    } sppm_state_t;
endpackage : sppm_pkg

// ---- sppm_slot_tick.sv ----
// Time-slot tick generator: module clock divided by 16 times divisor.
// Assumes a divisor held stable during a frame; zero stops the tick.
module sppm_slot_tick #(
    parameter int DIV_W = 13
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Control
    input wire logic [DIV_W-1:0] divisor_i,
    // Ticks
    output logic mid_tick_o,
    output logic slot_tick_o
);
    logic [DIV_W+3:0] cnt_reg;
    logic [DIV_W+3:0] top;

    assign top = {divisor_i, 4'h0} - {{DIV_W{1'b0}}, 4'h1};

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || divisor_i == '0) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= top) begin
            cnt_reg <= '0; // [RULE22]
        end else begin
            cnt_reg <= cnt_reg + (DIV_W + 4)'(1);
        end
    end

    assign slot_tick_o = (divisor_i != '0) && (cnt_reg >= top); // [RULE17] [RULE18]
    assign mid_tick_o = (divisor_i != '0) && (cnt_reg == {1'b0, top[DIV_W+3:1]});
endmodule : sppm_slot_tick

// ---- sppm_master.sv ----
// Functional notes
// RULE1: Frame is push field then slave pull field
// RULE2: Push: start, sync, five data, three address
// RULE3: Start holds line low three slots
// RULE4: Push sync bit is biphase zero
// RULE5: Data low five bits, address high three
// RULE6: Master sends pull sync biphase one
// RULE7: Pull bits NRZ, stored in data byte
// RULE8: Slave ends with 20kHz square wave
// RULE9: Push bits biphase, two slots each
// RULE10: Zero high-low, one low-high
// RULE11: Success: code not 111/000, square wave
// RULE12: Failing slave returns 111, line high
// RULE13: Slave samples each slot twice
// RULE14: Slave flags biphase and field errors
// RULE15: Push mismatch on receive pin sets noise
// RULE16: Eight low slots disable all outputs
// RULE17: Module clock is 16 n 40kHz
// RULE18: Slot is half push bit period
// RULE19: Receive pin ignored during push; automatic
// RULE20: Received byte 0101 sss1
// RULE21: Master may start frame any time
// RULE22: Slot tick divides clock by 16n
// RULE23: Receive-complete after byte stored
// Single-wire push-pull master framing logic, 40 MHz ref_clk_i.
// Assumes transmit_pin drives the bus through an inverting-free driver.
`include "sppm_cfg.svh"
module sppm_master
    import sppm_pkg::*;
#(
    parameter int DIV_W = 13
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Control
    input wire logic [DIV_W-1:0] baud_divisor_i,
    input wire logic [7:0] push_pull_data_low_byte_i,
    input wire logic send_i,
    input wire logic noise_clear_i,
    input wire logic done_clear_i,
    // Line
    input wire logic receive_pin_i,
    output logic transmit_pin_o,
    // Status
    output logic busy_o,
    output logic [7:0] push_pull_data_low_byte_o,
    output logic receive_done_o,
    output logic noise_status_flag_o,
    output logic frame_ok_o
);
    sppm_state_t state_reg;
    logic mid_tick;
    logic slot_tick;
    logic rx_s1_reg;
    logic rx_s2_reg;
    logic [7:0] tx_reg;
    logic [3:0] idx_reg;
    logic half_reg;
    logic [2:0] pull_reg;
    logic [2:0] eof_cnt_reg;
    logic eof_prev_reg;
    logic eof_ok_reg;
    logic tx_bit;
    logic tx_level;
    logic pending_reg;

    sppm_slot_tick #(.DIV_W(DIV_W)) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .divisor_i(baud_divisor_i),
        .mid_tick_o(mid_tick),
        .slot_tick_o(slot_tick)
    );

    function automatic logic biphase(input logic b, input logic second);
        biphase = second ? b : ~b; // [RULE10]
    endfunction : biphase

    // Receive pin synchroniser
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
        end else begin
            rx_s1_reg <= receive_pin_i;
            rx_s2_reg <= rx_s1_reg;
        end
    end

    // Send request held until a slot boundary
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pending_reg <= 1'b0;
        end else if (send_i) begin
            pending_reg <= 1'b1; // [RULE21]
        end else if (slot_tick) begin
            pending_reg <= 1'b0;
        end
    end

    // Push bit order: sync, data LSB first, then address
    assign tx_bit = (state_reg == SPPM_PSYNC) ? 1'b1 : // [RULE6]
                    (idx_reg == 4'h0) ? 1'b0 : tx_reg[idx_reg[2:0] - 3'h1]; // [RULE4] [RULE5]

    always_comb begin
        case (state_reg)
            SPPM_START: tx_level = 1'b0; // [RULE3]
            SPPM_PUSH: tx_level = biphase(tx_bit, half_reg); // [RULE9]
            SPPM_PSYNC: tx_level = biphase(tx_bit, half_reg);
            default: tx_level = 1'b1;
        endcase
    end

    // Frame sequencer
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= SPPM_IDLE;
            idx_reg <= 4'h0;
            half_reg <= 1'b0;
            tx_reg <= 8'h00;
        end else if (slot_tick) begin
            if (pending_reg) begin
                state_reg <= SPPM_START; // [RULE1] [RULE21]
                idx_reg <= 4'h0;
                half_reg <= 1'b0;
                tx_reg <= push_pull_data_low_byte_i; // [RULE5]
            end else begin
                case (state_reg)
                    SPPM_IDLE: state_reg <= SPPM_IDLE;
                    SPPM_START: begin
                        if (idx_reg == 4'(`SPPM_START_SLOTS - 1)) begin
                            state_reg <= SPPM_PUSH; // [RULE2]
                            idx_reg <= 4'h0;
                        end else begin
                            idx_reg <= idx_reg + 4'h1;
                        end
                    end
                    SPPM_PUSH: begin
                        half_reg <= ~half_reg;
                        if (half_reg) begin
                            if (idx_reg == 4'(`SPPM_DATA_BITS + `SPPM_ADDR_BITS)) begin
                                state_reg <= SPPM_PSYNC; // [RULE6]
                            end
                            idx_reg <= idx_reg + 4'h1;
                        end
                    end
                    SPPM_PSYNC: begin
                        half_reg <= ~half_reg;
                        if (half_reg) begin
                            state_reg <= SPPM_PULL;
                            idx_reg <= 4'h0;
                        end
                    end
                    SPPM_PULL: begin
                        idx_reg <= idx_reg + 4'h1;
                        if (idx_reg == 4'(`SPPM_PULL_BITS - 1)) begin
                            state_reg <= SPPM_EOF;
                            idx_reg <= 4'h0;
                        end
                    end
                    SPPM_EOF: begin
                        idx_reg <= idx_reg + 4'h1;
                        if (idx_reg == 4'(`SPPM_EOF_SLOTS - 1)) begin
                            state_reg <= SPPM_DONE;
                        end
                    end
                    SPPM_DONE: state_reg <= SPPM_IDLE;
                    default: state_reg <= SPPM_IDLE;
                endcase
            end
        end
    end

    // Pull sampling mid-slot, NRZ, first bit into S1 position
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pull_reg <= 3'h0;
        end else if (mid_tick && state_reg == SPPM_PULL) begin
            pull_reg <= {pull_reg[1:0], rx_s2_reg}; // [RULE7] [RULE19]
        end
    end

    // End-of-frame square wave check: level must toggle in at least two of the three slot-to-slot steps
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            eof_prev_reg <= 1'b1;
            eof_cnt_reg <= 3'h0;
            eof_ok_reg <= 1'b0;
        end else if (mid_tick) begin
            eof_prev_reg <= rx_s2_reg;
            if (state_reg == SPPM_EOF) begin
                if (idx_reg != 4'h0 && rx_s2_reg != eof_prev_reg) begin
                    eof_cnt_reg <= eof_cnt_reg + 3'h1;
                end
            end else if (state_reg == SPPM_PULL) begin
                eof_cnt_reg <= 3'h0;
            end
            eof_ok_reg <= (eof_cnt_reg >= 3'(`SPPM_EOF_SLOTS - 2)); // [RULE11]
        end
    end

    // Receive byte and completion
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            push_pull_data_low_byte_o <= 8'h00;
        end else if (slot_tick && state_reg == SPPM_PULL &&
                     idx_reg == 4'(`SPPM_PULL_BITS - 1)) begin
            push_pull_data_low_byte_o <= {`SPPM_RX_FIXED_HI, pull_reg, `SPPM_RX_FIXED_LO}; // [RULE20]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            receive_done_o <= 1'b0;
        end else if (slot_tick && state_reg == SPPM_PULL &&
                     idx_reg == 4'(`SPPM_PULL_BITS - 1)) begin
            receive_done_o <= 1'b1; // [RULE23]
        end else if (done_clear_i) begin
            receive_done_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            frame_ok_o <= 1'b0;
        end else if (state_reg == SPPM_START) begin
            frame_ok_o <= 1'b0;
        end else if (slot_tick && state_reg == SPPM_DONE) begin
            frame_ok_o <= eof_ok_reg && push_pull_data_low_byte_o[3:1] != 3'h7 &&
                          push_pull_data_low_byte_o[3:1] != 3'h0; // [RULE11] [RULE12]
        end
    end

    // Bit error: monitor the line against the driven push level
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            noise_status_flag_o <= 1'b0;
        end else if (mid_tick && (state_reg == SPPM_PUSH || state_reg == SPPM_PSYNC) &&
                     rx_s2_reg != tx_level) begin
            noise_status_flag_o <= 1'b1; // [RULE15]
        end else if (noise_clear_i) begin
            noise_status_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            transmit_pin_o <= 1'b1;
        end else begin
            transmit_pin_o <= tx_level;
        end
    end

    assign busy_o = (state_reg != SPPM_IDLE) || pending_reg;

    property p_start_low;
        @(posedge ref_clk_i) disable iff (rst_i)
        (state_reg == SPPM_START) |=> !transmit_pin_o;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start not low"); // [RULE3]

    property p_psync_one;
        @(posedge ref_clk_i) disable iff (rst_i)
        (state_reg == SPPM_PSYNC && !half_reg) |=> !transmit_pin_o;
    endproperty
    a_psync_one: assert property (p_psync_one) else $error("pull sync first half not low"); // [RULE6]

    property p_rx_pattern;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(receive_done_o) |-> push_pull_data_low_byte_o[7:4] == 4'h5 &&
                                  push_pull_data_low_byte_o[0];
    endproperty
    a_rx_pattern: assert property (p_rx_pattern) else $error("fixed pattern wrong"); // [RULE20]

    property p_idle_high;
        @(posedge ref_clk_i) disable iff (rst_i)
        (state_reg == SPPM_IDLE && $past(state_reg) == SPPM_IDLE) |=> transmit_pin_o;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle line not released"); // [RULE1]

    property p_noise_set;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mid_tick && state_reg == SPPM_PUSH && rx_s2_reg != tx_level) |=> noise_status_flag_o;
    endproperty
    a_noise_set: assert property (p_noise_set) else $error("bit error missed"); // [RULE15]

    property p_ok_code;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(frame_ok_o) |-> push_pull_data_low_byte_o[3:1] != 3'h7 &&
                              push_pull_data_low_byte_o[3:1] != 3'h0;
    endproperty
    a_ok_code: assert property (p_ok_code) else $error("bad code judged ok"); // [RULE11]

    property p_push_biphase;
        @(posedge ref_clk_i) disable iff (rst_i)
        (slot_tick && state_reg == SPPM_PUSH && half_reg) |-> tx_level == tx_bit;
    endproperty
    a_push_biphase: assert property (p_push_biphase) else $error("biphase second half wrong"); // [RULE10]

    property p_tick_period;
        @(posedge ref_clk_i) disable iff (rst_i)
        (slot_tick && baud_divisor_i == 13'h0001 && $stable(baud_divisor_i)) |=> !slot_tick [*8];
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("slot tick too early"); // [RULE22]
endmodule : sppm_master

// ---- sppm_slave_model.sv ----
// Behavioural slave on the shared wire, answering each push field.
// Assumes a pulled-up wire: line low only when someone drives it.
module sppm_slave_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Bus and behaviour
    input wire logic line_i,
    input wire logic [12:0] divisor_i,
    input wire logic [2:0] status_i,
    input wire logic fail_i,
    output logic drive_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic active_reg;
    logic err_reg;
    logic qa_reg;
    logic first_reg;
    logic start_seen;
    int cnt_reg;
    int low_reg;
    int slot;
    int ph;
    assign slot = cnt_reg / (16 * int'(divisor_i));
    assign ph = cnt_reg % (16 * int'(divisor_i));
    assign start_seen = !drive_low_o && !line_i && low_reg == 40 * int'(divisor_i) - 1;
    // Start seen after 2.5 low slots not driven by this model
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || drive_low_o || line_i) begin
            low_reg <= 0;
        end else begin
            low_reg <= low_reg + 1;
        end
    end
    // Slot counter of the current frame
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            active_reg <= 1'b0;
            cnt_reg <= 0;
        end else if (low_reg >= 128 * int'(divisor_i)) begin
            active_reg <= 1'b0;
        end else if (start_seen) begin
            active_reg <= 1'b1;
            cnt_reg <= 40 * int'(divisor_i);
        end else if (active_reg) begin
            cnt_reg <= cnt_reg + 1;
            if (slot >= 30) begin
                active_reg <= 1'b0;
            end
        end
    end
    // Push field checks: two samples a slot, biphase pairs, sync bit
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || start_seen) begin
            err_reg <= 1'b0;
            qa_reg <= 1'b1;
            first_reg <= 1'b1;
        end else if (active_reg && slot >= 3 && slot <= 20) begin
            if (ph == 4 * int'(divisor_i)) begin
                qa_reg <= line_i;
            end else if (ph == 12 * int'(divisor_i)) begin
                first_reg <= line_i;
                if (line_i != qa_reg || (!slot[0] && line_i == first_reg) ||
                    (slot == 3 && !line_i)) begin
                    err_reg <= 1'b1;
                end
            end
        end
    end
    // Pull bits NRZ one slot each, then end-of-frame square wave
    always_comb begin
        drive_low_o = 1'b0;
        if (active_reg && slot >= 23 && slot <= 25) begin
            drive_low_o = ~(status_i[25 - slot] | fail_i | err_reg);
        end else if (active_reg && slot >= 26 && slot <= 29) begin
            drive_low_o = ~(fail_i | err_reg) & ~slot[0];
        end
    end
endmodule : sppm_slave_model

// ---- tb_top.sv ----
// Self-checking bench of the push-pull master with one slave model.
// Assumes divisor n gives 16*n clocks a slot at 40 MHz.
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic send_i = 1'b0;
    logic noise_clear_i = 1'b0;
    logic done_clear_i = 1'b0;
    logic jam = 1'b0;
    logic fail = 1'b0;
    logic [12:0] div = 13'h0001;
    logic [7:0] push_byte = 8'h00;
    logic [2:0] status = 3'h0;
    logic tx, busy, done, noise, ok, slave_low;
    logic [7:0] rx_byte;
    wire logic line = tx & ~slave_low & ~jam;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    sppm_master dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .baud_divisor_i(div),
        .push_pull_data_low_byte_i(push_byte), .send_i(send_i),
        .noise_clear_i(noise_clear_i), .done_clear_i(done_clear_i),
        .receive_pin_i(line), .transmit_pin_o(tx), .busy_o(busy),
        .push_pull_data_low_byte_o(rx_byte), .receive_done_o(done),
        .noise_status_flag_o(noise), .frame_ok_o(ok));
    sppm_slave_model slave (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .line_i(line),
        .divisor_i(div), .status_i(status), .fail_i(fail), .drive_low_o(slave_low));
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 12000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic pulse(input int sel);
        if (sel == 0) begin
            send_i <= 1'b1;
        end else if (sel == 1) begin
            noise_clear_i <= 1'b1;
        end else begin
            done_clear_i <= 1'b1;
        end
        @(posedge ref_clk_i);
        send_i <= 1'b0;
        noise_clear_i <= 1'b0;
        done_clear_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : pulse
    task automatic run_frame(input logic [7:0] b, input logic [2:0] st, input logic f,
                             input logic j);
        logic [22:0] expw;
        logic v;
        int sl;
        int low;
        int k;
        sl = 16 * int'(div);
        expw = 23'h400000;
        for (k = 0; k < 9; k++) begin
            v = (k == 0) ? 1'b0 : b[k-1];
            expw[3+2*k] = ~v;
            expw[4+2*k] = v;
        end
        @(posedge ref_clk_i);
        status <= st;
        fail <= f;
        pulse(2);
        push_byte <= b;
        pulse(0);
        low = 0;
        for (k = 0; k < 40 * sl && low < 5 * sl / 2; k++) begin
            @(posedge ref_clk_i);
            low = tx ? 0 : low + 1;
        end
        `CHK(low, 5 * sl / 2)
        jam <= j;
        repeat (sl + 1) @(posedge ref_clk_i);
        for (k = 3; k < 23; k++) begin
            if (k > 3) repeat (sl) @(posedge ref_clk_i);
            `CHK(tx, expw[k])
            jam <= 1'b0;
        end
        for (k = 0; k < 8 * sl && done !== 1'b1; k++) @(posedge ref_clk_i);
        `CHK(done, 1'b1)
        `CHK(rx_byte, {4'h5, ((f || j) ? 3'h7 : st), 1'b1})
        for (k = 0; k < 8 * sl && busy !== 1'b0; k++) @(posedge ref_clk_i);
        `CHK(ok, !f && !j && st != 3'h0 && st != 3'h7)
        `CHK(noise, j)
        pulse(1);
        pulse(2);
        `CHK(noise, 1'b0)
        `CHK(done, 1'b0)
    endtask : run_frame
    task automatic t_reset();
        `CHK(tx, 1'b1)
        `CHK({busy, done, noise, ok, rx_byte}, 12'h000)
        $display("test reset done");
    endtask : t_reset
    task automatic t_valid();
        run_frame(8'ha5, 3'b101, 1'b0, 1'b0);
        $display("test valid done");
    endtask : t_valid
    task automatic t_codes();
        run_frame(8'h1f, 3'b000, 1'b0, 1'b0);
        run_frame(8'he0, 3'b111, 1'b1, 1'b0);
        $display("test codes done");
    endtask : t_codes
    task automatic t_bit_error();
        run_frame(8'h5a, 3'b010, 1'b0, 1'b1);
        $display("test bit error done");
    endtask : t_bit_error
    task automatic t_break_in();
        push_byte <= 8'h3c;
        pulse(0);
        repeat (200) @(posedge ref_clk_i);
        run_frame(8'hc3, 3'b110, 1'b0, 1'b0);
        $display("test break in done");
    endtask : t_break_in
    task automatic t_slow_divisor();
        div <= 13'h0002;
        @(posedge ref_clk_i);
        run_frame(8'h96, 3'b011, 1'b0, 1'b0);
        div <= 13'h0001;
        $display("test slow divisor done");
    endtask : t_slow_divisor
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_reset();
        t_valid();
        t_codes();
        t_bit_error();
        t_break_in();
        t_slow_divisor();
        print_verdict();
    end
endmodule : tb_top
